// ==== rtl/bbmb_board.sv ====
/*
 one byte-wide storage board: lower and upper 1k groups of bit-wide cells,
 shared write data, selected read data, presence line and slot select.
 assumes the memory controller drives address, data and write enable
 synchronously to clk and drains read bytes through the read fifo.
*/
`timescale 1ns/1ns
// What this block does
// - the board holds a lower and an upper group, each 1k bytes built from eight bit-wide cell arrays.
// - each cell array has 1024 cells addressed in parallel by the ten low address lines.
// - each write-data line feeds the same bit of both groups.
// - each read-data line comes from the same bit of both groups and only the selected group drives it.
// - the bank-select address bit is 0 for the first 1024 addresses (lower) and 1 above (upper).
// - a group is selected only when the bank bit matches and the board's module select is active.
// - with write enable low and a group selected the write byte is stored at the address.
// - with write enable high and a group selected the addressed byte is presented on the read lines.
// - the first-slot board grounds its presence line.
// - boards in slots two to four also ground the first-slot presence line; they have no presence line of their own.
// - boards in slots two to four answer their own module-select line.
// - a board operates only when all lower slots are occupied.
// - a memory-full indication lights once 2048 writes have reached this board, repeated addresses included.
// - the reported size is 2048 bytes per board, up to 8192 bytes.
module bbmb_board
    import bbmb_pkg::*;
#(
    parameter int ADDR_W = BBMB_WORD_ADDR_W,
    parameter int DATA_W = BBMB_DATA_W,
    parameter int FIFO_DEPTH = BBMB_FIFO_DEPTH,
    parameter bbmb_slot_e SLOT = BBMB_SLOT_FIRST
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic bank_select_address_bit,
    input wire logic [BBMB_MAX_BOARDS-1:0] module_select,
    input wire logic write_enable_n,
    input wire logic [DATA_W-1:0] write_data_line_lsb,
    input wire logic [BBMB_MAX_BOARDS-1:0] lower_slots_present_n,
    output logic [DATA_W-1:0] read_data_line_lsb,
    output logic read_data_oe_n,
    output logic read_valid,
    input wire logic read_ready,
    output logic access_ready,
    output logic board_present_first_slot,
    output logic memory_full,
    output logic [13:0] memory_size_bytes
);
    localparam int WORDS = 1 << ADDR_W;
    initial begin
        if (WORDS != BBMB_GROUP_WORDS || DATA_W != BBMB_DATA_W) begin
            $error("board geometry must be 1024 words of 8 bits");
        end
    end

    // ****************************************
    // selection
    // ****************************************
    logic my_select;
    logic slot_enabled;
    logic sel_lower;
    logic sel_upper;
    logic group_sel;
    logic fifo_in_ready;
    logic fifo_has_room;
    logic do_write;
    logic do_read;
    assign my_select = module_select[SLOT];
    assign slot_enabled = (SLOT == BBMB_SLOT_FIRST) ? 1'b1 :
        (lower_slots_present_n & ((BBMB_MAX_BOARDS)'(1) << SLOT) - 1'b1) == '0;
    assign sel_lower = my_select && slot_enabled && (bank_select_address_bit == BBMB_BANK_LOWER);
    assign sel_upper = my_select && slot_enabled && (bank_select_address_bit == BBMB_BANK_UPPER);
    assign group_sel = sel_lower || sel_upper;
    // a read stalls while the fifo is full, so no byte is dropped
    assign access_ready = !group_sel || write_enable_n == 1'b0 || fifo_has_room;
    assign do_write = group_sel && !write_enable_n;
    assign do_read = group_sel && write_enable_n && fifo_has_room;
    assign board_present_first_slot = BBMB_PRESENT_GROUNDED;

    // ****************************************
    // bit-wide cell arrays
    // ****************************************
    logic [DATA_W-1:0] rd_lower;
    logic [DATA_W-1:0] rd_upper;
    logic bank_upper_reg;
    logic read_pending_reg;
    genvar b;
    generate
        for (b = 0; b < DATA_W; b++) begin : g_bit
            logic lower_cells [WORDS];
            logic upper_cells [WORDS];
            logic lower_q_reg;
            logic upper_q_reg;
            always_ff @(posedge clk) begin
                if (do_write && sel_lower) begin
                    lower_cells[word_address] <= write_data_line_lsb[b];
                end
                if (do_write && sel_upper) begin
                    upper_cells[word_address] <= write_data_line_lsb[b];
                end
                lower_q_reg <= lower_cells[word_address];
                upper_q_reg <= upper_cells[word_address];
            end
            assign rd_lower[b] = lower_q_reg;
            assign rd_upper[b] = upper_q_reg;
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_pending_reg <= 1'b0;
            bank_upper_reg <= BBMB_BANK_LOWER;
        end else begin
            read_pending_reg <= do_read;
            bank_upper_reg <= sel_upper;
        end
    end

    // ****************************************
    // read path fifo
    // ****************************************
    logic [DATA_W-1:0] fifo_q;
    bbmb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(read_pending_reg),
        .in_ready(fifo_in_ready),
        .in_data(bank_upper_reg ? rd_upper : rd_lower),
        .out_valid(read_valid),
        .out_ready(read_ready),
        .out_data(fifo_q)
    );
    // reads in flight in the array stage count as occupied, otherwise the
    // one-cycle array latency lets a back-to-back read overrun a full fifo
    localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
    logic [OCC_W-1:0] occupancy_reg;
    assign fifo_has_room = (occupancy_reg != OCC_W'(FIFO_DEPTH));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            occupancy_reg <= '0;
        end else begin
            occupancy_reg <= occupancy_reg + OCC_W'(do_read) - OCC_W'(read_valid && read_ready);
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data_line_lsb <= BBMB_DATA_RESET;
            read_data_oe_n <= 1'b1;
        end else begin
            read_data_line_lsb <= fifo_q;
            read_data_oe_n <= !(read_valid && !(read_ready && read_valid));
        end
    end

    // ****************************************
    // fill tracking and size
    // ****************************************
    logic [ADDR_W:0] written_reg;
    logic full_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            written_reg <= '0;
            full_reg <= 1'b0;
        end else if (do_write && !full_reg) begin
            written_reg <= written_reg + 1'b1;
            full_reg <= (written_reg == (ADDR_W+1)'(2*WORDS - 1));
        end
    end
    assign memory_full = full_reg;
    assign memory_size_bytes = slot_enabled ? 14'((int'(SLOT) + 1) * BBMB_BOARD_BYTES) : 14'h0000;

    AST_WRITE_NOT_READ: assert property (@(posedge clk) disable iff (!reset_n)
        do_write |-> !do_read) else $error("write and read at once");
    AST_READ_ENQUEUED: assert property (@(posedge clk) disable iff (!reset_n)
        do_read |=> read_pending_reg) else $error("read not queued");
    AST_UNSELECTED_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !my_select |-> !do_write && !do_read) else $error("unselected board acts");
    AST_BANK_LOWER: assert property (@(posedge clk) disable iff (!reset_n)
        (my_select && slot_enabled && !bank_select_address_bit) |-> sel_lower && !sel_upper)
        else $error("lower group not selected");
    AST_GROUP_NEEDS_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
        group_sel |-> my_select) else $error("group without module select");
    AST_PRESENT: assert property (@(posedge clk) disable iff (!reset_n)
        board_present_first_slot == BBMB_PRESENT_GROUNDED) else $error("presence not grounded");
    AST_FULL_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
        full_reg |=> full_reg) else $error("full dropped");
    AST_SIZE_MAX: assert property (@(posedge clk) disable iff (!reset_n)
        memory_size_bytes <= 14'(BBMB_MAX_BYTES)) else $error("size too large");
    AST_READ_NOT_DROPPED: assert property (@(posedge clk) disable iff (!reset_n)
        read_pending_reg |-> fifo_in_ready) else $error("read byte dropped at full fifo");
    AST_BANK_UPPER: assert property (@(posedge clk) disable iff (!reset_n)
        (my_select && slot_enabled && bank_select_address_bit) |-> sel_upper && !sel_lower)
        else $error("upper group not selected");
    AST_SLOT_GATED: assert property (@(posedge clk) disable iff (!reset_n)
        !slot_enabled |-> !group_sel) else $error("disabled slot selected");
    AST_LINES_RELEASED: assert property (@(posedge clk) disable iff (!reset_n)
        !read_valid |=> read_data_oe_n) else $error("read lines driven with no byte");
    AST_SIZE_STEP: assert property (@(posedge clk) disable iff (!reset_n)
        (memory_size_bytes % 14'(BBMB_BOARD_BYTES)) == 14'h0000) else $error("size not whole boards");
endmodule

// ==== rtl/bbmb_fifo.sv ====
/*
 small synchronous fifo with valid/ready on both sides.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module bbmb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("fifo depth must be a power of two of at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!reset_n)
        count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ==== rtl/bbmb_pkg.sv ====
/*
 memory board constants: geometry, bank split, slot numbering.
 assumes a single synchronous clock domain around the board.
*/
package bbmb_pkg;
    localparam int BBMB_WORD_ADDR_W = 10;
    localparam int BBMB_DATA_W = 8;
    localparam int BBMB_GROUP_WORDS = 1024;
    localparam int BBMB_BOARD_BYTES = 2048;
    localparam int BBMB_MAX_BOARDS = 4;
    localparam int BBMB_MAX_BYTES = 8192;
    localparam int BBMB_FIFO_DEPTH = 4;
    localparam logic BBMB_BANK_LOWER = 1'h0;
    localparam logic BBMB_BANK_UPPER = 1'h1;
    localparam logic BBMB_PRESENT_GROUNDED = 1'h0;
    localparam logic [BBMB_DATA_W-1:0] BBMB_DATA_RESET = 8'h00;
    typedef enum logic [1:0] {
        BBMB_SLOT_FIRST = 2'b00,
        BBMB_SLOT_SECOND = 2'b01,
        BBMB_SLOT_THIRD = 2'b10,
        BBMB_SLOT_FOURTH = 2'b11
    } bbmb_slot_e;
endpackage

// ==== tb/bbmb_board_test.sv ====
/*
 testbench for the memory board in the first slot.
 assumes the controller model and the board share clk.
*/
`timescale 1ns/1ns
module bbmb_board_test;
    import bbmb_pkg::*;
    // ****************************************
    // bench
    // ****************************************
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic read_ready = 1'h0;
    logic [3:0] lower_slots_present_n = 4'h0;
    logic [9:0] word_address;
    logic bank_select_address_bit, write_enable_n, read_data_oe_n, read_valid, access_ready;
    logic board_present_first_slot, memory_full;
    logic [3:0] module_select;
    logic [7:0] write_data_line_lsb, read_data_line_lsb;
    logic [13:0] memory_size_bytes;
    int n_fail = 0;
    int n_tests = 0;
    initial forever #2 clk = ~clk;
    bbmb_board bbmb_board_i (.clk(clk), .reset_n(reset_n), .word_address(word_address),
        .bank_select_address_bit(bank_select_address_bit), .module_select(module_select),
        .write_enable_n(write_enable_n), .write_data_line_lsb(write_data_line_lsb),
        .lower_slots_present_n(lower_slots_present_n), .read_data_line_lsb(read_data_line_lsb),
        .read_data_oe_n(read_data_oe_n), .read_valid(read_valid), .read_ready(read_ready),
        .access_ready(access_ready), .board_present_first_slot(board_present_first_slot),
        .memory_full(memory_full), .memory_size_bytes(memory_size_bytes));
    bbmb_ctrl_model bbmb_ctrl_model_i (.clk(clk), .access_ready(access_ready), .word_address(word_address),
        .bank_select_address_bit(bank_select_address_bit), .module_select(module_select),
        .write_enable_n(write_enable_n), .write_data_line_lsb(write_data_line_lsb));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for the head byte, checks it, then pops it
    task automatic pop(input logic [7:0] exp);
        int k;
        k = 0;
        #1;
        while (read_valid !== 1'h1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
        chk(read_data_line_lsb, exp);
        chk(read_data_oe_n, 1'h0);
        @(posedge clk);
        read_ready <= 1'h1;
        @(posedge clk);
        read_ready <= 1'h0;
    endtask
    task automatic t_reset();
        @(posedge clk);
        #1;
        chk(read_data_oe_n, 1'h1);
        chk(board_present_first_slot, BBMB_PRESENT_GROUNDED);
        chk(memory_size_bytes, 14'h0800);
        chk(memory_full, 1'h0);
    endtask
    task automatic t_banks();
        bbmb_ctrl_model_i.req(4'h1, 1'h0, 1'h0, 10'h005, 8'ha5);
        bbmb_ctrl_model_i.req(4'h1, 1'h0, 1'h1, 10'h005, 8'h5a);
        bbmb_ctrl_model_i.req(4'h1, 1'h1, 1'h0, 10'h005, 8'h00);
        bbmb_ctrl_model_i.req(4'h1, 1'h1, 1'h1, 10'h005, 8'h00);
        bbmb_ctrl_model_i.idle();
        pop(8'ha5);
        pop(8'h5a);
    endtask
    // other slots' selects must neither write nor drive this board
    task automatic t_unsel();
        bbmb_ctrl_model_i.req(4'he, 1'h0, 1'h0, 10'h005, 8'hff);
        bbmb_ctrl_model_i.req(4'he, 1'h1, 1'h0, 10'h005, 8'h00);
        bbmb_ctrl_model_i.idle();
        repeat (4) @(posedge clk);
        #1;
        chk(read_valid, 1'h0);
        chk(read_data_oe_n, 1'h1);
        bbmb_ctrl_model_i.req(4'h1, 1'h1, 1'h0, 10'h005, 8'h00);
        bbmb_ctrl_model_i.idle();
        pop(8'ha5);
    endtask
    task automatic t_fifo();
        bbmb_ctrl_model_i.req(4'h1, 1'h0, 1'h0, 10'h3fe, 8'h10);
        for (int i = 1; i < 4; i++) bbmb_ctrl_model_i.wr_next(8'h10 + 8'(i));
        for (int i = 0; i < 4; i++) bbmb_ctrl_model_i.req(4'h1, 1'h1, 1'(i > 1), 10'h3fe + 10'(i), 8'h00);
        #1;
        chk(access_ready, 1'h0);
        bbmb_ctrl_model_i.idle();
        repeat (4) @(posedge clk);
        #1;
        chk(read_valid, 1'h1);
        for (int i = 0; i < 4; i++) pop(8'h10 + 8'(i));
        repeat (3) @(posedge clk);
        #1;
        chk(read_valid, 1'h0);
        chk(read_data_oe_n, 1'h1);
    endtask
    task automatic t_full();
        while (bbmb_ctrl_model_i.n_writes < 2047) bbmb_ctrl_model_i.wr_next(8'h33);
        bbmb_ctrl_model_i.idle();
        repeat (3) @(posedge clk);
        #1;
        chk(memory_full, 1'h0);
        bbmb_ctrl_model_i.wr_next(8'h44);
        bbmb_ctrl_model_i.idle();
        repeat (3) @(posedge clk);
        #1;
        chk(memory_full, 1'h1);
    endtask
    task automatic report_and_stop();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // expected run is about 2200 cycles; the limit leaves ample margin
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        t_reset();
        t_banks();
        t_unsel();
        t_fifo();
        t_full();
        report_and_stop();
    end
endmodule

// ==== tb/bbmb_ctrl_model.sv ====
/*
 memory controller model: drives address, data, select and write enable.
 assumes the board samples requests on the rising edge of clk.
*/
`timescale 1ns/1ns
module bbmb_ctrl_model
    import bbmb_pkg::*;
(
    input wire logic clk,
    input wire logic access_ready,
    output logic [BBMB_WORD_ADDR_W-1:0] word_address,
    output logic bank_select_address_bit,
    output logic [BBMB_MAX_BOARDS-1:0] module_select,
    output logic write_enable_n,
    output logic [BBMB_DATA_W-1:0] write_data_line_lsb
);
    // ****************************************
    // request drivers
    // ****************************************
    int n_writes = 0;
    logic cur_bk = 1'h0;
    logic [9:0] cur_a = 10'h000;
    initial begin
        word_address = 10'h000;
        bank_select_address_bit = 1'h0;
        module_select = 4'h0;
        write_enable_n = 1'h1;
        write_data_line_lsb = 8'h00;
    end
    // held until the taking edge; reads wait for access_ready
    task automatic req(input logic [3:0] sel, input logic we_n, input logic bk, input logic [9:0] a,
                       input logic [7:0] d);
        module_select <= sel;
        write_enable_n <= we_n;
        bank_select_address_bit <= bk;
        word_address <= a;
        write_data_line_lsb <= d;
        cur_bk = bk;
        cur_a = a;
        @(negedge clk);
        while (we_n && access_ready !== 1'h1) @(negedge clk);
        @(posedge clk);
        if (sel[0] && !we_n) n_writes++;
    endtask
    // released data lines show the inverse, never the old byte
    task automatic idle();
        module_select <= 4'h0;
        write_enable_n <= 1'h1;
        write_data_line_lsb <= ~write_data_line_lsb;
        @(posedge clk);
    endtask
    task automatic wr_next(input logic [7:0] d);
        logic [10:0] nxt;
        nxt = {cur_bk, cur_a} + 11'h001;
        req(4'h1, 1'h0, nxt[10], nxt[9:0], d);
    endtask
endmodule
